/* File: logic/ves_map.svh */
// Register map, field positions, reset values and level constants of the volume envelope shaper
`ifndef VES_MAP_SVH
`define VES_MAP_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define VES_OFS_SHAPE 12'h000
`define VES_OFS_ENV 12'h004
`define VES_OFS_STATUS 12'h008
`define VES_OFS_PEAK 12'h00C

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define VES_KLOC_LSB 0
`define VES_KNEE_LSB 8
`define VES_VELO_LSB 16
`define VES_DLOC_LSB 24
`define VES_RISE_LSB 0
`define VES_FALL_LSB 8
`define VES_DAMP_LSB 16
`define VES_STAT_FALL_BIT 16
`define VES_STAT_DAMP_BIT 17

// ----------------------------------------------------------------
// Reset values (all shaping defeated)
// ----------------------------------------------------------------
`define VES_RST_CODE6 6'h00
`define VES_RST_CODE5 5'h00
`define VES_RST_LEVEL 16'h0000

// ----------------------------------------------------------------
// Level scale: 16'hFFFF is 0dB, 16'h8000 is -48dB
// ----------------------------------------------------------------
`define VES_LVL_M48DB 16'h8000
`define VES_KLOC_STEP 16'h0208
`define VES_DLOC_STEP 16'h0210
`define VES_DLOC_FIRST 6'h01
`define VES_KNEE_UNITY 6'h08
`define VES_KNEE_SHIFT 3
`define VES_VELO_SHIFT 2
`define VES_RATE_FULL 7'h40
`define VES_RATE_SHIFT 6
`define VES_LVL_MAX 16'hFFFF

// ----------------------------------------------------------------
// Reserved bits of the setting words, always read as zero
// ----------------------------------------------------------------
`define VES_SHAPE_RSVD 32'hC0E0E0C0
`define VES_ENV_RSVD 32'hFFC0C0C0

`endif

/* File: logic/ves_pkg.sv */
// Types shared by the volume envelope shaper and its bench
package ves_pkg;
    // One volume sample with its strobe
    typedef struct packed {
        logic valid;
        logic [15:0] level;
    } ves_sample_t;

    // Envelope phase
    typedef enum logic {VES_RISING, VES_FALLING} ves_env_state_t;

    // Shaping settings written by software
    typedef struct packed {
        logic [5:0] kloc;
        logic [4:0] knee;
        logic [4:0] velo;
        logic [5:0] dloc;
        logic [5:0] rise;
        logic [5:0] fall;
        logic [5:0] damp;
    } ves_cfg_t;
endpackage

/* File: logic/ves_volume_envelope_shaper.sv */
// Volume envelope shaper: knee, hand-speed add, peak hold and envelope with APB settings
//
// The APB slave port and the register addresses were decided locally.
`include "ves_map.svh"

// Function
// R1: Knee and hand-speed run in parallel, then peak hold, then envelope.
// R2: Below knee threshold volume gets steeper by knee amount; above it unchanged.
// R3: Knee amount zero passes volume through the knee unit unchanged.
// R4: Knee threshold codes 0 to 63 span -48dB to 0dB linearly.
// R5: Upward hand speed times gain is added everywhere, no threshold.
// R6: Envelope rises toward peak, slower for larger rise; falls once reached.
// R7: Rise zero makes envelope jump to the peak at once.
// R8: Beyond switch point the damp rate is used, otherwise the fall rate.
// R9: Larger fall or damp setting gives a slower downward ramp.
// R10: Switch codes 1 to 63 span -48dB to 0dB; zero disables damp.
// R11: Rise, fall and damp (or switch) zero leave volume untouched.
// R12: Settings are six-bit, knee amount and hand-speed gain five-bit.
// R13: Peak hold keeps the maximum and releases it along the envelope fall.
module ves_volume_envelope_shaper (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire ves_pkg::ves_sample_t vol_in,
    output ves_pkg::ves_sample_t vol_out
);
    import ves_pkg::*;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------

    // Threshold level for a setting code
    function automatic logic [15:0] thr_of(input logic [5:0] code, input logic [5:0] first,
                                           input logic [15:0] step);
        logic [21:0] prod;
        prod = 22'({10'h000, step[11:0]} * 22'(code - first));
        thr_of = `VES_LVL_M48DB + prod[15:0];
    endfunction

    // Saturating add of two levels
    function automatic logic [15:0] sat_add(input logic [15:0] a, input logic [15:0] b);
        logic [16:0] sum;
        sum = {1'b0, a} + {1'b0, b};
        sat_add = sum[16] ? `VES_LVL_MAX : sum[15:0];
    endfunction

    // One step from cur toward tgt; code zero arrives at once, larger codes step less
    function automatic logic [15:0] approach(input logic [15:0] cur, input logic [15:0] tgt,
                                             input logic [5:0] code);
        logic [15:0] diff;
        logic [22:0] prod;
        logic [15:0] step;
        diff = (tgt > cur) ? tgt - cur : cur - tgt;
        prod = 23'(diff) * 23'(`VES_RATE_FULL - 7'(code));
        step = prod[21:6];
        if (step == 16'h0000 && diff != 16'h0000) begin
            step = 16'h0001;
        end
        approach = (tgt > cur) ? cur + step : cur - step;
    endfunction

    // ----------------------------------------------------------------
    // Settings and state
    // ----------------------------------------------------------------
    ves_cfg_t cfg;
    logic [15:0] prev_level;
    logic [15:0] comb_q;
    logic damp_q;
    logic a_valid;
    logic [15:0] env;
    logic [15:0] peak;
    ves_env_state_t env_state;
    logic acc_phase;
    logic addr_ok;
    logic addr_rw;

    // ----------------------------------------------------------------
    // APB slave
    // ----------------------------------------------------------------

    // Address decode; status and peak words are read only
    always_comb begin
        addr_ok = 1'b1;
        addr_rw = 1'b0;
        unique case (paddr)
            `VES_OFS_SHAPE, `VES_OFS_ENV: addr_rw = 1'b1;
            `VES_OFS_STATUS, `VES_OFS_PEAK: addr_rw = 1'b0;
            default: addr_ok = 1'b0;
        endcase
    end

    assign acc_phase = psel & penable & ~pready;

    // Writes land on the first access edge; the answer one edge later carries the error flag
    // One wait state, then answer with registered data and error
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= acc_phase;
            pslverr <= acc_phase & (~addr_ok | (pwrite & ~addr_rw));
            prdata <= 32'h00000000;
            if (acc_phase && !pwrite) begin
                unique case (paddr)
                    `VES_OFS_SHAPE: begin
                        prdata[`VES_KLOC_LSB +: 6] <= cfg.kloc;
                        prdata[`VES_KNEE_LSB +: 5] <= cfg.knee;
                        prdata[`VES_VELO_LSB +: 5] <= cfg.velo;
                        prdata[`VES_DLOC_LSB +: 6] <= cfg.dloc;
                    end
                    `VES_OFS_ENV: begin
                        prdata[`VES_RISE_LSB +: 6] <= cfg.rise;
                        prdata[`VES_FALL_LSB +: 6] <= cfg.fall;
                        prdata[`VES_DAMP_LSB +: 6] <= cfg.damp;
                    end
                    `VES_OFS_STATUS: begin
                        prdata[15:0] <= env;
                        prdata[`VES_STAT_FALL_BIT] <= (env_state == VES_FALLING);
                        prdata[`VES_STAT_DAMP_BIT] <= damp_q;
                    end
                    `VES_OFS_PEAK: prdata[15:0] <= peak;
                    default: prdata <= 32'h00000000;
                endcase
            end
        end
    end

    // Settings registers, written at the first access edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg.kloc <= `VES_RST_CODE6;
            cfg.knee <= `VES_RST_CODE5;
            cfg.velo <= `VES_RST_CODE5;
            cfg.dloc <= `VES_RST_CODE6;
            cfg.rise <= `VES_RST_CODE6;
            cfg.fall <= `VES_RST_CODE6;
            cfg.damp <= `VES_RST_CODE6;
        end else if (psel && penable && pwrite && !pready) begin
            // R12: field widths
            if (paddr == `VES_OFS_SHAPE) begin
                cfg.kloc <= pwdata[`VES_KLOC_LSB +: 6];
                cfg.knee <= pwdata[`VES_KNEE_LSB +: 5];
                cfg.velo <= pwdata[`VES_VELO_LSB +: 5];
                cfg.dloc <= pwdata[`VES_DLOC_LSB +: 6];
            end else if (paddr == `VES_OFS_ENV) begin
                cfg.rise <= pwdata[`VES_RISE_LSB +: 6];
                cfg.fall <= pwdata[`VES_FALL_LSB +: 6];
                cfg.damp <= pwdata[`VES_DAMP_LSB +: 6];
            end
        end
    end

    // ----------------------------------------------------------------
    // Stage A: knee and hand-speed in parallel
    // ----------------------------------------------------------------
    logic [15:0] kthr;
    logic [15:0] dthr;
    logic [15:0] knee_out;
    logic [15:0] speed_add;
    logic [15:0] next_comb;
    logic next_damp;

    // R4: knee threshold scale
    assign kthr = thr_of(cfg.kloc, `VES_RST_CODE6, `VES_KLOC_STEP);
    // R10: switch point scale from code one
    assign dthr = thr_of(cfg.dloc, `VES_DLOC_FIRST, `VES_DLOC_STEP);

    // Knee expansion and upward speed term
    always_comb begin
        logic [15:0] below;
        logic [21:0] expd;
        logic [15:0] up;
        logic [20:0] sp;
        below = kthr - vol_in.level;
        expd = 22'(below) * 22'(`VES_KNEE_UNITY + 6'(cfg.knee));
        expd = expd >> `VES_KNEE_SHIFT;
        up = (vol_in.level > prev_level) ? vol_in.level - prev_level : 16'h0000;
        sp = 21'(up) * 21'(cfg.velo);
        sp = sp >> `VES_VELO_SHIFT;
        // R2: steeper below threshold only; R3: knee zero gives unity slope
        if (vol_in.level >= kthr || cfg.knee == 5'h00) begin
            knee_out = vol_in.level;
        end else if (expd >= 22'(kthr)) begin
            knee_out = `VES_RST_LEVEL;
        end else begin
            knee_out = kthr - expd[15:0];
        end
        // Speed term reads the raw input so a deep knee cannot hide hand speed
        // R5: rising hand only, whole field
        speed_add = (sp[20:16] != 5'h00) ? `VES_LVL_MAX : sp[15:0];
        // R1: combine both units
        next_comb = sat_add(knee_out, speed_add);
        // Damp selection reads the raw hand level, not the shaped one
        // R8: damp beyond switch point
        next_damp = (cfg.dloc != `VES_RST_CODE6) && (vol_in.level >= dthr);
    end

    // Register stage A results
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_level <= `VES_RST_LEVEL;
            comb_q <= `VES_RST_LEVEL;
            damp_q <= 1'b0;
            a_valid <= 1'b0;
        end else begin
            a_valid <= vol_in.valid;
            if (vol_in.valid) begin
                prev_level <= vol_in.level;
                comb_q <= next_comb;
                damp_q <= next_damp;
            end
        end
    end

    // ----------------------------------------------------------------
    // Stage B: peak hold and envelope
    // ----------------------------------------------------------------
    logic [15:0] pk;
    logic [15:0] next_env;
    logic [15:0] next_peak;
    logic [5:0] fall_rate;
    ves_env_state_t next_state;

    // R13: capture maximum of combined result
    assign pk = (comb_q > peak) ? comb_q : peak;
    // R8: rate select; R9: larger code means smaller step
    assign fall_rate = damp_q ? cfg.damp : cfg.fall;

    // Envelope rise toward peak, then fall toward the live level
    always_comb begin
        if (env < pk) begin
            // R6: rise toward peak; R7: rise zero jumps
            next_env = approach(env, pk, cfg.rise);
            next_state = VES_RISING;
            next_peak = pk;
        end else begin
            // R11: rate code zero hands the live level straight through
            // R9: fall ramp; R13: peak released along the fall
            next_env = approach(env, comb_q, fall_rate);
            next_state = VES_FALLING;
            next_peak = next_env;
        end
    end

    // Envelope registers and output sample
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            env <= `VES_RST_LEVEL;
            peak <= `VES_RST_LEVEL;
            env_state <= VES_RISING;
            vol_out <= '0;
        end else begin
            vol_out.valid <= a_valid;
            if (a_valid) begin
                env <= next_env;
                peak <= next_peak;
                env_state <= next_state;
                vol_out.level <= next_env;
            end
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence in_take_s;
        vol_in.valid;
    endsequence

    sequence out_emit_s;
        ##2 vol_out.valid;
    endsequence

    sample_path_a: assert property (in_take_s |-> out_emit_s) // R1
        else $error("sample did not reach output after two cycles");
    // Stage A results
    knee_above_a: assert property (vol_in.valid && vol_in.level >= kthr && cfg.velo == 5'h00 // R2
        |=> comb_q == $past(vol_in.level)) else $error("knee altered level above threshold");
    knee_steeper_a: assert property (vol_in.valid && vol_in.level < kthr && cfg.velo == 5'h00 // R2
        |=> comb_q <= $past(vol_in.level)) else $error("knee raised level below threshold");
    knee_bypass_a: assert property (vol_in.valid && cfg.knee == 5'h00 && cfg.velo == 5'h00 // R3
        |=> comb_q == $past(vol_in.level)) else $error("knee zero changed level");
    speed_down_a: assert property (vol_in.valid && vol_in.level <= prev_level && cfg.knee == 5'h00 // R5
        |=> comb_q == $past(vol_in.level)) else $error("speed term added on falling hand");
    // Stage B results and damp selection
    rise_ramp_a: assert property (a_valid && cfg.rise != 6'h00 && env < pk // R6
        |=> env > $past(env) && env <= $past(pk)) else $error("rise did not move toward peak");
    rise_instant_a: assert property (a_valid && cfg.rise == 6'h00 && env < pk // R7
        |=> env == $past(pk)) else $error("rise zero did not jump to peak");
    damp_select_a: assert property (vol_in.valid && cfg.dloc != 6'h00 && vol_in.level >= dthr // R8
        |=> damp_q) else $error("damp not selected beyond switch point");
    damp_off_a: assert property (vol_in.valid && cfg.dloc == 6'h00 |=> !damp_q) // R10
        else $error("damp selected with switch disabled");
    fall_ramp_a: assert property (a_valid && env >= pk && env > comb_q // R9
        |=> env < $past(env) && env >= $past(comb_q)) else $error("fall overshot or stalled");
    env_bypass_a: assert property (a_valid && cfg.rise == 6'h00 && fall_rate == 6'h00 // R11
        |=> vol_out.level == $past(comb_q)) else $error("bypassed envelope altered volume");
    peak_hold_a: assert property (a_valid |=> peak >= $past(comb_q) && peak >= env // R13
        && (env_state == VES_RISING || peak == env)) else $error("peak lost the maximum");

    // Register bus answer and read words
    sequence apb_take_s;
        psel && penable && !pready;
    endsequence

    sequence apb_answer_s;
        ##1 pready;
    endsequence

    apb_wait_a: assert property (apb_take_s |-> apb_answer_s)
        else $error("register access not answered after one wait state");
    ro_write_err_a: assert property (psel && penable && !pready && pwrite
        && (paddr == `VES_OFS_STATUS || paddr == `VES_OFS_PEAK) |=> pslverr && pready)
        else $error("write to a read-only word not refused");
    err_with_ready_a: assert property (pslverr |-> pready)
        else $error("error flag raised outside an answer");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h00000000)
        else $error("read data not zero outside an answer");
    shape_rsvd_a: assert property (pready && !pwrite && paddr == `VES_OFS_SHAPE // R12
        |-> (prdata & `VES_SHAPE_RSVD) == 32'h00000000) else $error("shape word reserved bits set");
    env_rsvd_a: assert property (pready && !pwrite && paddr == `VES_OFS_ENV // R12
        |-> (prdata & `VES_ENV_RSVD) == 32'h00000000) else $error("rate word reserved bits set");
    status_word_a: assert property (pready && !pwrite && paddr == `VES_OFS_STATUS // R8
        |-> prdata[15:0] == $past(env) && prdata[`VES_STAT_DAMP_BIT] == $past(damp_q)
        && prdata[`VES_STAT_FALL_BIT] == $past(env_state == VES_FALLING))
        else $error("status word does not show envelope state");
    peak_word_a: assert property (pready && !pwrite && paddr == `VES_OFS_PEAK // R13
        |-> prdata[15:0] == $past(peak)) else $error("peak word does not show peak hold");

    // Output level between samples
    out_hold_a: assert property (!a_valid |=> vol_out.level == $past(vol_out.level)) // R6
        else $error("output level moved without a sample");
endmodule

/* File: verification/ves_chain_model.sv */
// Upstream volume chain model that feeds samples into the shaper
module ves_chain_model (
    input wire logic send,
    input wire logic [15:0] lvl,
    output ves_pkg::ves_sample_t vol_in
);
    timeunit 1ns;
    timeprecision 1ns;
    import ves_pkg::*;

    // Level means nothing off the strobe, so show its inverse there
    assign vol_in = {send, send ? lvl : ~lvl};
endmodule

/* File: verification/tb_volume_envelope_shaper.sv */
// Self-checking bench for the volume envelope shaper
`include "ves_map.svh"
module tb_volume_envelope_shaper;
    timeunit 1ns;
    timeprecision 1ns;
    import ves_pkg::*;

    // ----------------------------------------
    // Signals and instances
    // ----------------------------------------
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic send = 1'b0;
    logic [15:0] lvl = 16'h0000;
    ves_sample_t vol_in;
    ves_sample_t vol_out;
    logic [31:0] rd;
    logic er;
    int bad_count = 0;
    int num_checks = 0;

    ves_volume_envelope_shaper u_ves_volume_envelope_shaper (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .vol_in(vol_in), .vol_out(vol_out)
    );

    ves_chain_model u_ves_chain_model (.send(send), .lvl(lvl), .vol_in(vol_in));

    // Clock at 100 ns period
    always #50 pclk = ~pclk;

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One APB transfer, held until pready is seen at an edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        check("pready", 32'h1, {31'h0, pready});
        check("wait cycles", 32'h0000_0002, 32'(n));
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input logic experr);
        apb(1'b0, a, 32'h0);
        check("read data", exp, rd);
        check("read error", {31'h0, experr}, {31'h0, er});
    endtask

    // One sample in, answer two cycles later
    task automatic smp(input logic [15:0] l, input logic [15:0] exp);
        send <= 1'b1;
        lvl <= l;
        @(posedge pclk);
        send <= 1'b0;
        #1 check("out valid early", 32'h0, {31'h0, vol_out.valid});
        @(posedge pclk);
        #1 check("out valid", 32'h1, {31'h0, vol_out.valid});
        check("out level", {16'h0, exp}, {16'h0, vol_out.level});
        @(posedge pclk);
    endtask

    // Fresh reset, then both setting words
    task automatic cfg(input logic [31:0] shape, input logic [31:0] env);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b1, `VES_OFS_SHAPE, shape);
        apb(1'b1, `VES_OFS_ENV, env);
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdchk(`VES_OFS_SHAPE, 32'h0000_0000, 1'b0);
        rdchk(`VES_OFS_ENV, 32'h0000_0000, 1'b0);
        rdchk(`VES_OFS_PEAK, 32'h0000_0000, 1'b0);
        rdchk(12'h010, 32'h0000_0000, 1'b1);
        apb(1'b1, `VES_OFS_STATUS, 32'hFFFF_FFFF);
        check("status write error", 32'h1, {31'h0, er});
        apb(1'b1, `VES_OFS_SHAPE, 32'hFFFF_FFFF);
        rdchk(`VES_OFS_SHAPE, 32'h3F1F_1F3F, 1'b0);
        apb(1'b1, `VES_OFS_ENV, 32'hFFFF_FFFF);
        rdchk(`VES_OFS_ENV, 32'h003F_3F3F, 1'b0);
        $display("test registers done");
        cfg(32'h0000_0000, 32'h0000_0000);
        smp(16'h1234, 16'h1234);
        smp(16'h1235, 16'h1235);
        smp(16'h0100, 16'h0100);
        $display("test bypass done");
        cfg(32'h0000_083F, 32'h0000_0000);
        smp(16'hF000, 16'hE008);
        smp(16'hFFFC, 16'hFFFC);
        cfg(32'h0000_0800, 32'h0000_0000);
        smp(16'h7000, 16'h6000);
        smp(16'h9000, 16'h9000);
        cfg(32'h0000_1F3F, 32'h0000_0000);
        smp(16'h0100, 16'h0000);
        cfg(32'h0000_003F, 32'h0000_0000);
        smp(16'hF000, 16'hF000);
        $display("test knee done");
        cfg(32'h0004_0000, 32'h0000_0000);
        smp(16'h0000, 16'h0000);
        smp(16'h1000, 16'h2000);
        smp(16'h0800, 16'h0800);
        smp(16'hC000, 16'hFFFF);
        $display("test speed done");
        cfg(32'h0000_0000, 32'h0000_0020);
        smp(16'h8000, 16'h4000);
        smp(16'h8000, 16'h6000);
        $display("test rise done");
        cfg(32'h0000_0000, 32'h0000_2000);
        smp(16'hF000, 16'hF000);
        smp(16'h9000, 16'hC000);
        rdchk(`VES_OFS_PEAK, 32'h0000_C000, 1'b0);
        cfg(32'h0100_0000, 32'h0030_2000);
        smp(16'hF000, 16'hF000);
        smp(16'h9000, 16'hD800);
        rdchk(`VES_OFS_STATUS, 32'h0003_D800, 1'b0);
        cfg(32'h0000_0000, 32'h0030_2000);
        smp(16'hF000, 16'hF000);
        smp(16'h9000, 16'hC000);
        cfg(32'h0000_0000, 32'h0028_0000);
        smp(16'hF000, 16'hF000);
        smp(16'h9000, 16'h9000);
        $display("test fall done");
        end_sim();
    end

    // Watchdog well beyond the expected run length
    initial begin
        #3_000_000;
        bad_count++;
        end_sim();
    end
endmodule
